// ==== rtc_cal_pkg.sv ====
// Shared constants for the calendar and alarm timekeeper
package rtc_cal_pkg;

  // Register offsets
  localparam logic [7:0] OFS_WEEKDAY   = 8'h03;
  localparam logic [7:0] OFS_DATE      = 8'h04;
  localparam logic [7:0] OFS_MONTH     = 8'h05;
  localparam logic [7:0] OFS_YEAR      = 8'h06;
  localparam logic [7:0] OFS_CONTROL   = 8'h07;
  localparam logic [7:0] OFS_ALM0_BASE = 8'h0A;
  localparam logic [7:0] OFS_ALM1_BASE = 8'h11;

  // Register index inside one alarm unit
  localparam logic [2:0] ALM_IDX_SEC   = 3'h0;
  localparam logic [2:0] ALM_IDX_MIN   = 3'h1;
  localparam logic [2:0] ALM_IDX_HOUR  = 3'h2;
  localparam logic [2:0] ALM_IDX_DAY_OF_WEEK_FIELD = 3'h3;
  localparam logic [2:0] ALM_IDX_DATE  = 3'h4;
  localparam logic [2:0] ALM_IDX_MONTH = 3'h5;

  // Weekday and month register bit positions
  localparam int WK_OSC_RUN_BIT  = 5;
  localparam int WK_PWR_LOSS_BIT = 4;
  localparam int WK_BACKUP_BIT   = 3;
  localparam int MTH_LEAP_BIT    = 5;

  // Control register bit positions
  localparam int CTL_GP_OUT_BIT = 7;
  localparam int CTL_SQW_BIT    = 6;
  localparam int CTL_ALM1_BIT   = 5;
  localparam int CTL_ALM0_BIT   = 4;

  // Alarm weekday and alarm hour register bit positions
  localparam int AW_POL_BIT  = 7;
  localparam int AW_MSK_LSB  = 4;
  localparam int AW_FLAG_BIT = 3;
  localparam int AHR_FMT_BIT = 6;

  // Field masks
  localparam logic [7:0] MASK_DATE  = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_SEC   = 8'h7F;
  localparam logic [7:0] MASK_HOUR  = 8'h3F;

  // Reset values and BCD limits
  localparam logic [7:0] RST_ONE    = 8'h01;
  localparam logic [7:0] BCD_ZERO   = 8'h00;
  localparam logic [7:0] LAST_MONTH = 8'h12;
  localparam logic [7:0] LAST_YEAR  = 8'h99;
  localparam logic [2:0] LAST_DAY_OF_WEEK_FIELD = 3'h7;
  localparam logic [2:0] FIRST_DAY_OF_WEEK_FIELD = 3'h1;

  // Alarm match select codes
  localparam logic [2:0] MSK_SEC   = 3'b000;
  localparam logic [2:0] MSK_MIN   = 3'b001;
  localparam logic [2:0] MSK_HOUR  = 3'b010;
  localparam logic [2:0] MSK_DAY_OF_WEEK_FIELD = 3'b011;
  localparam logic [2:0] MSK_DATE  = 3'b100;
  localparam logic [2:0] MSK_ALL   = 3'b111;

endpackage : rtc_cal_pkg

// ==== alarm_match_unit.sv ====
// One alarm unit: match registers, mask compare and match flag
`timescale 1ns/10ps
`default_nettype none

module alarm_match_unit (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Register access
  input  wire logic       wrEn,
  input  wire logic [2:0] wrIdx,
  input  wire logic [7:0] wrData,
  input  wire logic [2:0] rdIdx,
  output logic      [7:0] rdData,
  // Running time
  input  wire logic [7:0] curSeconds,
  input  wire logic [7:0] curMinutes,
  input  wire logic [7:0] curHours,
  input  wire logic [2:0] curWeekday,
  input  wire logic [7:0] curDate,
  input  wire logic [7:0] curMonth,
  // Control and status
  input  wire logic       unitEnable,
  output logic            matchFlag,
  output logic            polarity
);
  import rtc_cal_pkg::*;

  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic       pol;
    logic [2:0] msk;
    logic       flag;
    logic [2:0] day_of_week_field;
    logic [5:0] date;
    logic [4:0] mth;
  } alm_state_t;

  alm_state_t st_r;
  alm_state_t st_nxt;
  logic       matchNow;

  ////////////////////////////////////////////////////////////////////////////
  // Hours compare covers AM/PM and tens bits in the running format
  always_comb begin
    case (st_r.msk)
      MSK_SEC:   matchNow = (st_r.sec == curSeconds[6:0]);
      MSK_MIN:   matchNow = (st_r.min == curMinutes[6:0]);
      MSK_HOUR:  matchNow = (st_r.hour == curHours[5:0]); // R23
      MSK_DAY_OF_WEEK_FIELD: matchNow = (st_r.day_of_week_field == curWeekday);
      MSK_DATE:  matchNow = (st_r.date == curDate[5:0]);
      MSK_ALL:   matchNow = (st_r.sec == curSeconds[6:0])
                          && (st_r.min == curMinutes[6:0])
                          && (st_r.hour == curHours[5:0])
                          && (st_r.day_of_week_field == curWeekday)
                          && (st_r.date == curDate[5:0])
                          && (st_r.mth == curMonth[4:0]); // R24
      default:   matchNow = 1'b0; // R16
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    if (wrEn) begin
      case (wrIdx)
        ALM_IDX_SEC:   st_nxt.sec = wrData[6:0]; // R18 R20
        ALM_IDX_MIN:   st_nxt.min = wrData[6:0];
        ALM_IDX_HOUR:  st_nxt.hour = wrData[5:0];
        ALM_IDX_DAY_OF_WEEK_FIELD: begin
          st_nxt.pol   = wrData[AW_POL_BIT];
          st_nxt.msk   = wrData[AW_MSK_LSB +: 3];
          st_nxt.day_of_week_field = wrData[2:0];
          st_nxt.flag  = 1'b0; // R22
        end
        ALM_IDX_DATE:  st_nxt.date = wrData[5:0];
        ALM_IDX_MONTH: st_nxt.mth = wrData[4:0];
        default:       st_nxt = st_r;
      endcase
    end
    // Set beats a same-cycle clear; a lasting match re-sets the flag
    if (matchNow && unitEnable) begin
      st_nxt.flag = 1'b1; // R12 R13
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= '0;
      st_r.day_of_week_field <= FIRST_DAY_OF_WEEK_FIELD;
      st_r.date  <= RST_ONE[5:0];
      st_r.mth   <= RST_ONE[4:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (rdIdx)
      ALM_IDX_SEC:   rdData = {1'b0, st_r.sec};
      ALM_IDX_MIN:   rdData = {1'b0, st_r.min};
      ALM_IDX_HOUR:  rdData = {1'b0, curHours[AHR_FMT_BIT], st_r.hour};
      ALM_IDX_DAY_OF_WEEK_FIELD: rdData = {st_r.pol, st_r.msk, st_r.flag, st_r.day_of_week_field};
      ALM_IDX_DATE:  rdData = {2'b00, st_r.date};
      ALM_IDX_MONTH: rdData = {3'b000, st_r.mth};
      default:       rdData = BCD_ZERO;
    endcase
  end

  assign matchFlag = st_r.flag;
  assign polarity  = st_r.pol;

endmodule : alarm_match_unit
`default_nettype wire

// ==== calendar_alarm_timekeeper.sv ====
// Calendar registers, supply status, two alarms and pin routing
//
// Behaviour
// (R1) Weekday bit 5 reads oscillator running
// (R2) Power loss sets bit 4, clear wipes stamps
// (R3) No new stamp while power loss flag set
// (R4) Software never sets it; weekday write clears
// (R5) Weekday bit 3 enables backup supply input
// (R6) Day of week in bits 2-0, 1..7
// (R7) Date is BCD, tens 0-3, bits 7-6 zero
// (R8) Month bit 5 reads leap year flag
// (R9) Month is BCD, tens bit 4, ones 3-0
// (R10) Year is two BCD digits
// (R11) Two identical independent alarm units
// (R12) Hardware sets match flag, software clears it
// (R13) Clearing during ongoing match sets flag again
// (R14) Pin in alarm mode: alarm on, no square wave
// (R15) Alarm output works on backup supply
// (R16) Mask codes pick compared fields; 101,110 reserved
// (R17) Host configures alarm in prescribed order
// (R18) Alarm seconds at 0x0A and 0x11
// (R19) Host writes only valid BCD alarm values
// (R20) Alarm seconds tens 0-5, ones 0-9
// (R21) Polarity 1 asserts high, 0 asserts low; pin uses alarm 0 polarity for both alarms
// (R22) Alarm weekday write clears its match flag
// (R23) Hours match respects 12/24 hour format
// (R24) Compare all masked fields against running time
// (R25) Leap year when two-digit year divisible by four
`timescale 1ns/10ps
`default_nettype none

module calendar_alarm_timekeeper #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [7:0]        regRdData,
  // Running time from the counter chain
  input  wire logic [7:0]        curSeconds,
  input  wire logic [7:0]        curMinutes,
  input  wire logic [7:0]        curHours,
  input  wire logic              dayCarry,
  // Oscillator and supply
  input  wire logic              oscRunningAsync,
  input  wire logic              powerLossEvent,
  output logic                   stampCapture,
  output logic                   stampClear,
  output logic                   backupSupplyEnable,
  output logic                   squareWaveEnable,
  // Multi-function pin, open drain
  output logic                   mfpOut,
  output logic                   mfpOe
);
  import rtc_cal_pkg::*;

  if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
    $error("ADDR_W must lie between 5 and 8");
  end

  typedef struct packed {
    logic       oscMeta;
    logic       oscSync;
    logic       pwrLoss;
    logic       backupEn;
    logic [2:0] day_of_week_field;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] ctrl;
    logic [7:0] rdData;
    logic       capture;
    logic       clear;
    logic       pinLevel;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // BCD helpers
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcdInc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcdInc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcdInc

  // Divisible by four: even tens with 0,4,8 or odd tens with 2,6
  function automatic logic isLeap(input logic [7:0] y);
    if (y[4]) begin
      isLeap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      isLeap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4)
            || (y[3:0] == 4'h8);
    end
  endfunction : isLeap

  function automatic logic [7:0] lastDay(input logic [7:0] m,
                                         input logic       leap);
    case (m)
      8'h02:   lastDay = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDay = 8'h30;
      default: lastDay = 8'h31;
    endcase
  endfunction : lastDay

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Each alarm window is six registers; gaps between them read zero
  logic [7:0] addr8;
  logic       hitAlm0;
  logic       hitAlm1;
  logic [7:0] idx0;
  logic [7:0] idx1;
  logic [7:0] alm0Rd;
  logic [7:0] alm1Rd;
  logic       alm0Flag;
  logic       alm1Flag;
  logic       alm0Pol;
  logic       leapNow;

  assign addr8   = 8'(regAddr);
  assign idx0    = addr8 - OFS_ALM0_BASE;
  assign idx1    = addr8 - OFS_ALM1_BASE;
  assign hitAlm0 = (addr8 >= OFS_ALM0_BASE)
                && (addr8 <= OFS_ALM0_BASE + 8'h05);
  assign hitAlm1 = (addr8 >= OFS_ALM1_BASE)
                && (addr8 <= OFS_ALM1_BASE + 8'h05);
  assign leapNow = isLeap(st_r.year); // R25

  ////////////////////////////////////////////////////////////////////////////
  // Alarm units
  alarm_match_unit u_alarm0 (
    .clk        (clk),
    .reset_n    (reset_n),
    .wrEn       (regWrEn && hitAlm0),
    .wrIdx      (idx0[2:0]),
    .wrData     (regWrData),
    .rdIdx      (idx0[2:0]),
    .rdData     (alm0Rd),
    .curSeconds (curSeconds),
    .curMinutes (curMinutes),
    .curHours   (curHours),
    .curWeekday (st_r.day_of_week_field),
    .curDate    (st_r.date),
    .curMonth   (st_r.month),
    .unitEnable (st_r.ctrl[CTL_ALM0_BIT]),
    .matchFlag  (alm0Flag),
    .polarity   (alm0Pol)
  ); // R11

  alarm_match_unit u_alarm1 (
    .clk        (clk),
    .reset_n    (reset_n),
    .wrEn       (regWrEn && hitAlm1),
    .wrIdx      (idx1[2:0]),
    .wrData     (regWrData),
    .rdIdx      (idx1[2:0]),
    .rdData     (alm1Rd),
    .curSeconds (curSeconds),
    .curMinutes (curMinutes),
    .curHours   (curHours),
    .curWeekday (st_r.day_of_week_field),
    .curDate    (st_r.date),
    .curMonth   (st_r.month),
    .unitEnable (st_r.ctrl[CTL_ALM1_BIT]),
    .matchFlag  (alm1Flag),
    .polarity   ()
  ); // R11

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic almMode;
    logic almActive;
    logic monthWrap;
    almMode   = 1'b0;
    almActive = 1'b0;
    monthWrap = 1'b0;
    st_nxt    = st_r;

    // Oscillator status crosses in through two flops
    st_nxt.oscMeta = oscRunningAsync;
    st_nxt.oscSync = st_r.oscMeta;
    st_nxt.capture = 1'b0;
    st_nxt.clear   = 1'b0;

    // Midnight carry through the calendar
    if (dayCarry) begin
      st_nxt.day_of_week_field = (st_r.day_of_week_field == LAST_DAY_OF_WEEK_FIELD) ? FIRST_DAY_OF_WEEK_FIELD
                                                : st_r.day_of_week_field + 3'h1; // R6
      if (st_r.date == lastDay(st_r.month, leapNow)) begin
        st_nxt.date = RST_ONE;
        monthWrap   = 1'b1;
      end else begin
        st_nxt.date = bcdInc(st_r.date);
      end
      if (monthWrap) begin
        if (st_r.month == LAST_MONTH) begin
          st_nxt.month = RST_ONE;
          st_nxt.year  = (st_r.year == LAST_YEAR) ? BCD_ZERO
                                                  : bcdInc(st_r.year);
        end else begin
          st_nxt.month = bcdInc(st_r.month);
        end
      end
    end

    // Software writes override the carry for the written register
    if (regWrEn) begin
      case (addr8)
        OFS_WEEKDAY: begin
          st_nxt.backupEn = regWrData[WK_BACKUP_BIT]; // R5
          st_nxt.day_of_week_field    = regWrData[2:0]; // R6
          st_nxt.pwrLoss  = 1'b0; // R4
          st_nxt.clear    = st_r.pwrLoss; // R2
        end
        OFS_DATE:    st_nxt.date = regWrData & MASK_DATE; // R7
        OFS_MONTH:   st_nxt.month = regWrData & MASK_MONTH; // R9
        OFS_YEAR:    st_nxt.year = regWrData; // R10
        OFS_CONTROL: st_nxt.ctrl = regWrData;
        default:     st_nxt.ctrl = st_r.ctrl;
      endcase
    end

    // A loss while the flag stands is dropped to keep the old stamp
    if (powerLossEvent && !st_r.pwrLoss) begin
      st_nxt.pwrLoss = 1'b1; // R2 R3
      st_nxt.capture = 1'b1;
      st_nxt.clear   = 1'b0;
    end

    // Registered read data
    if (regRdEn) begin
      case (addr8)
        OFS_WEEKDAY: st_nxt.rdData = {2'b00, st_r.oscSync, st_r.pwrLoss,
                                      st_r.backupEn, st_r.day_of_week_field}; // R1
        OFS_DATE:    st_nxt.rdData = st_r.date;
        OFS_MONTH:   st_nxt.rdData = {2'b00, leapNow,
                                      st_r.month[4:0]}; // R8
        OFS_YEAR:    st_nxt.rdData = st_r.year;
        OFS_CONTROL: st_nxt.rdData = st_r.ctrl;
        default: begin
          if (hitAlm0) begin
            st_nxt.rdData = alm0Rd;
          end else if (hitAlm1) begin
            st_nxt.rdData = alm1Rd;
          end else begin
            st_nxt.rdData = BCD_ZERO;
          end
        end
      endcase
    end

    // Pin routing; no supply gating so alarms survive on backup
    almMode   = (st_r.ctrl[CTL_ALM0_BIT] || st_r.ctrl[CTL_ALM1_BIT])
             && !st_r.ctrl[CTL_SQW_BIT]; // R14 R15
    almActive = (st_r.ctrl[CTL_ALM0_BIT] && alm0Flag)
             || (st_r.ctrl[CTL_ALM1_BIT] && alm1Flag);
    if (almMode) begin
      st_nxt.pinLevel = almActive ? alm0Pol : !alm0Pol; // R21
    end else if (!st_r.ctrl[CTL_SQW_BIT]) begin
      st_nxt.pinLevel = st_r.ctrl[CTL_GP_OUT_BIT];
    end else begin
      st_nxt.pinLevel = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r          <= '0;
      st_r.day_of_week_field    <= FIRST_DAY_OF_WEEK_FIELD;
      st_r.date     <= RST_ONE;
      st_r.month    <= RST_ONE;
      st_r.year     <= RST_ONE;
      st_r.pinLevel <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Pin level is registered, so it trails the match flag by a cycle
  assign regRdData          = st_r.rdData;
  assign stampCapture       = st_r.capture;
  assign stampClear         = st_r.clear;
  assign backupSupplyEnable = st_r.backupEn;
  assign squareWaveEnable   = st_r.ctrl[CTL_SQW_BIT];
  // Open drain: only ever pulls low
  assign mfpOut             = 1'b0;
  assign mfpOe              = !st_r.pinLevel;

endmodule : calendar_alarm_timekeeper
`default_nettype wire

// ==== calendar_alarm_timekeeper_sva.sv ====
// Port-level assertions for the calendar and alarm timekeeper
`timescale 1ns/10ps
`default_nettype none

module calendar_alarm_timekeeper_sva
  import rtc_cal_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0]        regWrData,
  input wire logic              regWrEn,
  input wire logic              regRdEn,
  input wire logic [7:0]        regRdData,
  // Supply and pin
  input wire logic              powerLossEvent,
  input wire logic              stampCapture,
  input wire logic              stampClear,
  input wire logic              backupSupplyEnable,
  input wire logic              squareWaveEnable,
  input wire logic              mfpOut,
  input wire logic              mfpOe
);
  logic wrWk;
  logic rdA;

  assign wrWk = regWrEn && regAddr == OFS_WEEKDAY;
  assign rdA  = regRdEn;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_capture_cause: assert property (stampCapture |-> $past(powerLossEvent))
    else $error("capture without loss event");
  a_capture_held: assert property (stampCapture && !wrWk ##1 powerLossEvent
    |=> !stampCapture) else $error("capture while flag set");
  a_clear_cause: assert property (stampClear |-> $past(wrWk))
    else $error("stamp clear without weekday write");
  a_backup_write: assert property (wrWk |=>
    backupSupplyEnable == $past(regWrData[WK_BACKUP_BIT]))
    else $error("backup enable not taken");
  a_sqw_release: assert property (squareWaveEnable && $past(squareWaveEnable)
    |-> !mfpOe && !mfpOut) else $error("pin driven in square wave mode");
  a_weekday_range: assert property (rdA && regAddr == OFS_WEEKDAY |=>
    regRdData[2:0] != 3'h0 && regRdData[7:6] == 2'b00)
    else $error("weekday out of range");
  a_date_top: assert property (rdA && regAddr == OFS_DATE |=>
    regRdData[7:6] == 2'b00) else $error("date top bits set");
  a_month_top: assert property (rdA && regAddr == OFS_MONTH |=>
    regRdData[7:6] == 2'b00) else $error("month top bits set");
  a_alarm_sec: assert property (rdA && (regAddr == OFS_ALM0_BASE ||
    regAddr == OFS_ALM1_BASE) |=> !regRdData[7])
    else $error("alarm seconds bit 7 set");
  a_year_echo: assert property (regWrEn && regAddr == OFS_YEAR ##2
    rdA && regAddr == OFS_YEAR |=> regRdData == $past(regWrData, 3))
    else $error("year read differs from write");
  a_unmapped_zero: assert property (rdA && regAddr == 8'h08
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
endmodule : calendar_alarm_timekeeper_sva

bind calendar_alarm_timekeeper calendar_alarm_timekeeper_sva #(
  .ADDR_W(ADDR_W)
) calendar_alarm_timekeeper_sva_inst (.clk, .reset_n, .regAddr, .regWrData,
  .regWrEn, .regRdEn, .regRdData, .powerLossEvent, .stampCapture, .stampClear,
  .backupSupplyEnable, .squareWaveEnable, .mfpOut, .mfpOe);

`default_nettype wire

// ==== reg_host_model.sv ====
// Register host standing in for the serial bus controller
`timescale 1ns/10ps
`default_nettype none

module reg_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData
);
  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
  end

  // Callers load only valid BCD, alarm setup in documented order
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clk);
    regWrEn   = 1'b0;
    // Released lines flip so a stale value is never trusted
    regAddr   = ~a;
    regWrData = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d       = regRdData;
  endtask : rd
endmodule : reg_host_model

`default_nettype wire

// ==== tb_calendar_alarm_timekeeper.sv ====
// Self-checking bench for the calendar and alarm timekeeper
`timescale 1ns/10ps
`default_nettype none

module tb_calendar_alarm_timekeeper;
  import rtc_cal_pkg::*;
  localparam logic [7:0] A0WK = OFS_ALM0_BASE + {5'h00, ALM_IDX_DAY_OF_WEEK_FIELD};
  localparam logic [7:0] A1WK = OFS_ALM1_BASE + {5'h00, ALM_IDX_DAY_OF_WEEK_FIELD};
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic [7:0] curSeconds = 8'h00;
  logic [7:0] curMinutes = 8'h00;
  logic [7:0] curHours = 8'h00;
  logic       oscRunningAsync = 1'b0;
  logic       powerLossEvent = 1'b0;
  logic       dayCarry = 1'b0;
  logic       stampCapture;
  logic       stampClear;
  logic       backupSupplyEnable;
  logic       squareWaveEnable;
  logic       mfpOut;
  logic       mfpOe;
  int         n_fail = 0;
  int         cmp_count = 0;

  always #20 clk = ~clk;

  calendar_alarm_timekeeper calendar_alarm_timekeeper_inst (.clk, .reset_n,
    .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .curSeconds,
    .curMinutes, .curHours, .dayCarry, .oscRunningAsync, .powerLossEvent,
    .stampCapture, .stampClear, .backupSupplyEnable, .squareWaveEnable,
    .mfpOut, .mfpOe);

  reg_host_model reg_host_model_inst (.clk, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_host_model_inst.rd(a, v);
    chk(v, exp);
  endtask : rc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_host_model_inst.wr(a, d);
  endtask : wr

  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rc(OFS_WEEKDAY, 8'h01);
    rc(OFS_DATE, 8'h01);
    rc(OFS_MONTH, 8'h01);
    rc(OFS_ALM0_BASE, 8'h00);
    rc(OFS_ALM1_BASE, 8'h00);
    rc(8'h08, 8'h00);
    oscRunningAsync = 1'b1;
    repeat (3) @(negedge clk);
    rc(OFS_WEEKDAY, 8'h21);
    oscRunningAsync = 1'b0;
    repeat (3) @(negedge clk);
    rc(OFS_WEEKDAY, 8'h01);
  endtask : t_regs

  task automatic t_masks;
    logic       hit;
    logic [2:0] m;
    // All fields equal, so only the reserved codes stay silent
    wr(OFS_ALM0_BASE, 8'h45);
    curSeconds = 8'h45;
    for (int i = 0; i < 8; i++) begin
      m   = i[2:0];
      hit = !(m == 3'b101 || m == 3'b110);
      wr(OFS_CONTROL, 8'h00);
      wr(A0WK, {1'b0, m, 4'h1});
      wr(OFS_CONTROL, 8'h10);
      repeat (2) @(negedge clk);
      chk({7'h00, mfpOe}, {7'h00, hit});
      rc(A0WK, {1'b0, m, hit, 3'h1});
    end
    wr(A0WK, 8'h01);
    rc(A0WK, 8'h09);
    curMinutes = 8'h01;
    // Old mask still matches at the first write; clear again as hosts must
    wr(A0WK, 8'h11);
    wr(A0WK, 8'h11);
    repeat (2) @(negedge clk);
    rc(A0WK, 8'h11);
    curSeconds = 8'h46;
    wr(A0WK, 8'h09);
    curMinutes = 8'h00;
    repeat (2) @(negedge clk);
    chk({7'h00, mfpOe}, 8'h00);
    rc(A0WK, 8'h01);
  endtask : t_masks

  task automatic t_pin;
    wr(A0WK, 8'h81);
    repeat (2) @(negedge clk);
    chk({7'h00, mfpOe}, 8'h01);
    curSeconds = 8'h45;
    repeat (2) @(negedge clk);
    chk({7'h00, mfpOe}, 8'h00);
    wr(OFS_CONTROL, 8'h00);
    wr(A0WK, 8'h01);
    wr(OFS_WEEKDAY, 8'h09);
    wr(OFS_ALM1_BASE, 8'h45);
    wr(A1WK, 8'h01);
    wr(OFS_CONTROL, 8'h20);
    repeat (2) @(negedge clk);
    chk({7'h00, mfpOe}, 8'h01);
    rc(A1WK, 8'h09);
    rc(A0WK, 8'h01);
    wr(OFS_CONTROL, 8'h60);
    repeat (2) @(negedge clk);
    chk({7'h00, mfpOe}, 8'h00);
    chk({7'h00, squareWaveEnable}, 8'h01);
    wr(OFS_CONTROL, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, mfpOe}, 8'h01);
  endtask : t_pin

  task automatic t_power;
    @(negedge clk);
    powerLossEvent = 1'b1;
    @(negedge clk);
    chk({7'h00, stampCapture}, 8'h01);
    @(negedge clk);
    chk({7'h00, stampCapture}, 8'h00);
    @(negedge clk);
    chk({7'h00, stampCapture}, 8'h00);
    powerLossEvent = 1'b0;
    rc(OFS_WEEKDAY, 8'h19);
    wr(OFS_WEEKDAY, 8'h1D);
    chk({7'h00, stampClear}, 8'h01);
    rc(OFS_WEEKDAY, 8'h0D);
    chk({7'h00, backupSupplyEnable}, 8'h01);
    wr(OFS_WEEKDAY, 8'h01);
    chk({7'h00, stampClear}, 8'h00);
    chk({7'h00, backupSupplyEnable}, 8'h00);
  endtask : t_power

  task automatic t_calendar;
    logic [7:0] yrs[5] = '{8'h24, 8'h23, 8'h00, 8'h96, 8'h99};
    int         yv;
    wr(OFS_DATE, 8'h31);
    rc(OFS_DATE, 8'h31);
    wr(OFS_MONTH, 8'h12);
    foreach (yrs[i]) begin
      yv = yrs[i][7:4] * 10 + yrs[i][3:0];
      wr(OFS_YEAR, yrs[i]);
      rc(OFS_YEAR, yrs[i]);
      rc(OFS_MONTH, {2'b00, yv % 4 == 0, 5'h12});
    end
  endtask : t_calendar

  // Year end rollover, then a leap February
  task automatic t_carry;
    wr(OFS_WEEKDAY, 8'h07);
    @(negedge clk);
    dayCarry = 1'b1;
    @(negedge clk);
    dayCarry = 1'b0;
    rc(OFS_WEEKDAY, 8'h01);
    rc(OFS_DATE, 8'h01);
    rc(OFS_MONTH, 8'h21);
    rc(OFS_YEAR, 8'h00);
    wr(OFS_MONTH, 8'h02);
    wr(OFS_DATE, 8'h28);
    wr(OFS_YEAR, 8'h24);
    @(negedge clk);
    dayCarry = 1'b1;
    @(negedge clk);
    dayCarry = 1'b0;
    rc(OFS_DATE, 8'h29);
    rc(OFS_MONTH, 8'h22);
    curHours = 8'h40;
    rc(OFS_ALM0_BASE + 8'h02, 8'h40);
  endtask : t_carry

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    t_regs();
    t_masks();
    t_pin();
    t_power();
    t_calendar();
    t_carry();
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    n_fail++;
    end_of_test();
  end
endmodule : tb_calendar_alarm_timekeeper

`default_nettype wire
